// [hw/acl_map.svh]
// register offsets, field positions, reset values for the indirect ACL path
// assumes inclusion by bare name from the access module and the testbench
//
// Functional notes
// R01: table code 010 in ctrl0[7:5] selects rule store
// R02: ctrl0[3:0] picks port one through five
// R03: ctrl1[7:0] gives byte offset within entry
// R04: data register 0xA0 moves the addressed byte
// R05: offsets 6,7 hold station address bits 15:0
// R06: offsets 8,9 hold the Ether Type value
// R07: software keeps each layer in its own entry
// R08: offset 8 is Ether Type upper byte
// R09: matching bytes read/write, reset to zero
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH

// ==========================================================
// register offsets on the management register port
`define ACL_OFS_CTRL0 8'h6E
`define ACL_OFS_CTRL1 8'h6F
`define ACL_OFS_DATA 8'hA0

// ==========================================================
// control field positions and codes
`define ACL_TABLE_HI 7
`define ACL_TABLE_LO 5
`define ACL_PORT_HI 3
`define ACL_PORT_LO 0
`define ACL_TABLE_CODE 3'h2
`define ACL_PORT_MIN 4'h1
`define ACL_PORT_MAX 4'h5
`define ACL_CTRL0_MASK 8'hEF
`define ACL_CTRL_RESET 8'h00
`define ACL_BYTE_RESET 8'h00

// ==========================================================
// layer 2 matching byte offsets within an entry
`define ACL_OFS_ADDR_HI 8'h06
`define ACL_OFS_ADDR_LO 8'h07
`define ACL_OFS_TYPE_HI 8'h08
`define ACL_OFS_TYPE_LO 8'h09

`endif

// [hw/acl_pkg.sv]
// types shared by the indirect ACL access block
// assumes acl_map.svh is on the include path
package acl_pkg;
  // which layer 2 matching field the last indirect access touched
  typedef enum logic [2:0] {
    ACL_FLD_NONE,
    ACL_FLD_ADDR_HI,
    ACL_FLD_ADDR_LO,
    ACL_FLD_TYPE_HI,
    ACL_FLD_TYPE_LO,
    ACL_FLD_OTHER
  } acl_field_t;

  // source of the next read answer
  typedef enum logic [1:0] {
    ACL_SRC_ZERO,
    ACL_SRC_CTRL0,
    ACL_SRC_CTRL1,
    ACL_SRC_MEM
  } acl_rsrc_t;
endpackage

// [hw/acl_byte_mem.sv]
// byte memory holding every port's rule entries
// assumes a single clock; read data are registered one edge after request
`timescale 1ns/1ps
`default_nettype none
module acl_byte_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  // ==========================================================
  // storage
  logic [DW-1:0] mem_reg [2**AW];

  // flops, not RAM: an unprogrammed entry must compare against zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= '0; // R09
      end
    end else if (ce && we) begin
      mem_reg[addr] <= wdata; // R09
    end
  end

  // registered read of the current address
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem_reg[addr];
    end
  end
endmodule // acl_byte_mem
`default_nettype wire

// [hw/acl_indirect_access.sv]
// indirect byte access into the per-port ACL rule store
// assumes register port signals come from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "acl_map.svh"
module acl_indirect_access
  import acl_pkg::*;
#(
  parameter int ENTRY_AW = 4,
  parameter int PORT_AW = 3
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic ind_reject,
  output acl_field_t field_kind
);
  localparam int MAW = ENTRY_AW + PORT_AW;

  // ==========================================================
  // helpers
  // selection is usable only for the ACL table, a real port, in-entry
  function automatic logic sel_ok(input logic [7:0] c0, input logic [7:0] c1);
    logic t_ok;
    logic p_ok;
    logic o_ok;
    t_ok = c0[`ACL_TABLE_HI:`ACL_TABLE_LO] == `ACL_TABLE_CODE; // R01
    p_ok = c0[`ACL_PORT_HI:`ACL_PORT_LO] >= `ACL_PORT_MIN &&
           c0[`ACL_PORT_HI:`ACL_PORT_LO] <= `ACL_PORT_MAX; // R02
    o_ok = (c1 >> ENTRY_AW) == 8'h00; // R03
    return t_ok && p_ok && o_ok;
  endfunction

  // port n entry occupies slot n-1; offset picks the byte in it
  function automatic logic [MAW-1:0] mem_index(input logic [7:0] c0,
                                               input logic [7:0] c1);
    logic [3:0] pidx;
    pidx = c0[`ACL_PORT_HI:`ACL_PORT_LO] - 4'h1; // R02
    return {pidx[PORT_AW-1:0], c1[ENTRY_AW-1:0]}; // R03
  endfunction

  // name of the layer 2 field behind an offset
  function automatic acl_field_t field_of(input logic [7:0] c1);
    acl_field_t f;
    f = ACL_FLD_OTHER;
    if (c1 == `ACL_OFS_ADDR_HI) begin
      f = ACL_FLD_ADDR_HI; // R05
    end else if (c1 == `ACL_OFS_ADDR_LO) begin
      f = ACL_FLD_ADDR_LO; // R05
    end else if (c1 == `ACL_OFS_TYPE_HI) begin
      f = ACL_FLD_TYPE_HI; // R06 R08
    end else if (c1 == `ACL_OFS_TYPE_LO) begin
      f = ACL_FLD_TYPE_LO; // R06
    end
    return f;
  endfunction

  // ==========================================================
  // decode
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  acl_rsrc_t rsrc_reg;
  logic rd_pend_reg;
  logic hit_ctrl0;
  logic hit_ctrl1;
  logic hit_data;
  logic sel_valid;
  logic mem_we;
  logic [MAW-1:0] mem_addr;
  logic [7:0] mem_rdata;

  assign hit_ctrl0 = reg_addr == `ACL_OFS_CTRL0;
  assign hit_ctrl1 = reg_addr == `ACL_OFS_CTRL1;
  assign hit_data = reg_addr == `ACL_OFS_DATA;
  assign sel_valid = sel_ok(ctrl0_reg, ctrl1_reg);
  // a data write outside the ACL table or port range is dropped
  assign mem_we = reg_wr && hit_data && sel_valid; // R01 R02 R04
  assign mem_addr = mem_index(ctrl0_reg, ctrl1_reg); // R03

  // ==========================================================
  // indirect control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_reg <= `ACL_CTRL_RESET;
    end else if (ce && reg_wr && hit_ctrl0) begin
      ctrl0_reg <= reg_wdata & `ACL_CTRL0_MASK; // R01 R02
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_reg <= `ACL_CTRL_RESET;
    end else if (ce && reg_wr && hit_ctrl1) begin
      ctrl1_reg <= reg_wdata; // R03
    end
  end

  // ==========================================================
  // rule store
  acl_byte_mem #(
    .AW(MAW),
    .DW(8)
  ) u_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(reg_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // read path: memory registers first, answer one edge later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_reg <= 1'b0;
      rsrc_reg <= ACL_SRC_ZERO;
    end else if (ce) begin
      rd_pend_reg <= reg_rd;
      if (hit_ctrl0) begin
        rsrc_reg <= ACL_SRC_CTRL0;
      end else if (hit_ctrl1) begin
        rsrc_reg <= ACL_SRC_CTRL1;
      end else if (hit_data && sel_valid) begin
        rsrc_reg <= ACL_SRC_MEM; // R04
      end else begin
        rsrc_reg <= ACL_SRC_ZERO; // unmapped or bad selection reads 0
      end
    end
  end

  // answer register; the source is latched so ctrl writes do not race it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= rd_pend_reg;
      if (rd_pend_reg) begin
        case (rsrc_reg)
          ACL_SRC_CTRL0: reg_rdata <= ctrl0_reg;
          ACL_SRC_CTRL1: reg_rdata <= ctrl1_reg;
          ACL_SRC_MEM: reg_rdata <= mem_rdata; // R04
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // status: rejected indirect accesses and last field touched
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_reject <= 1'b0;
    end else if (ce) begin
      ind_reject <= (reg_wr || reg_rd) && hit_data && !sel_valid; // R01 R02
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      field_kind <= ACL_FLD_NONE;
    end else if (ce && (reg_wr || reg_rd) && hit_data && sel_valid) begin
      field_kind <= field_of(ctrl1_reg); // R05 R06 R08
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_TABLE_GATE: assert property ( // R01
    mem_we |-> ctrl0_reg[7:5] == 3'h2)
    else $error("data write reached store without ACL table code");
  AST_PORT_RANGE: assert property ( // R02
    mem_we |-> ctrl0_reg[3:0] inside {[4'h1:4'h5]})
    else $error("data write reached store for port outside 1..5");
  AST_OFFSET_ADDR: assert property ( // R03
    mem_we |-> mem_addr[ENTRY_AW-1:0] == ctrl1_reg[ENTRY_AW-1:0])
    else $error("store address does not follow the offset register");
  AST_READ_TIMING: assert property ( // R04
    (reg_rd && ce) ##1 ce |=> reg_rvalid)
    else $error("read answer missing two edges after request");
  AST_WRITE_READBACK: assert property ( // R09
    (ce && mem_we) ##1 (ce && reg_rd && hit_data && !reg_wr) ##1 ce
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("byte read back differs from byte written");
  AST_REJECT_PULSE: assert property ( // R01
    (ce && reg_wr && hit_data && !sel_valid) |=> ind_reject)
    else $error("bad selection not flagged");
  AST_TYPE_HIGH: assert property ( // R08
    (ce && reg_wr && hit_data && sel_valid && ctrl1_reg == 8'h08)
      |=> field_kind == ACL_FLD_TYPE_HI)
    else $error("offset 8 not seen as Ether Type upper byte");
  AST_ADDR_LOW: assert property ( // R05
    (ce && reg_rd && hit_data && sel_valid && ctrl1_reg == 8'h07)
      |=> field_kind == ACL_FLD_ADDR_LO)
    else $error("offset 7 not seen as station address low byte");
  AST_TYPE_LOW: assert property ( // R06
    (ce && (reg_wr || reg_rd) && hit_data && sel_valid && ctrl1_reg == 8'h09)
      |=> field_kind == ACL_FLD_TYPE_LO)
    else $error("offset 9 not seen as Ether Type lower byte");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(ctrl0_reg) && $stable(ctrl1_reg) && $stable(reg_rvalid))
    else $error("state moved while clock enable low");

  // main scenarios, each wanted at least once per run
  COV_DATA_WRITE: cover property (ce && mem_we);
  COV_CE_HOLD: cover property (!ce && rd_pend_reg);
  COV_DATA_READ: cover property (ce && rd_pend_reg && rsrc_reg == ACL_SRC_MEM);
  COV_REJECT: cover property (ind_reject);
  COV_TYPE_LOW: cover property (field_kind == ACL_FLD_TYPE_LO);
endmodule // acl_indirect_access
`default_nettype wire

// [testbench/acl_indirect_access_test.sv]
// self-checking bench for the indirect ACL byte access path
// assumes hw/ sources compiled first and acl_map.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "acl_map.svh"

// ==========================================================
// compare helper: counts every check, reports a mismatch at once
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
  end \
end

module acl_indirect_access_test
  import acl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic ind_reject;
  acl_field_t field_kind;
  int num_errors = 0;
  int tests_run = 0;
  logic [3:0] bad_p [3] = '{4'h0, 4'h6, 4'hF};

  // ==========================================================
  // clock and design
  always #50 ref_clk = ~ref_clk;

  acl_indirect_access dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .ind_reject(ind_reject),
    .field_kind(field_kind)
  );

  // ==========================================================
  // access tasks
  // one-cycle write strobe; reject is a pulse in the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic exp_rj);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
    `CHK(ind_reject, exp_rj)
  endtask

  // bounded wait for the answer, reject pulse may come before it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp_d,
                        input logic exp_rj);
    logic got_rj;
    logic [7:0] got_d;
    logic seen;
    got_rj = 1'b0;
    got_d = 8'h00;
    seen = 1'b0;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      if (ind_reject === 1'b1) got_rj = 1'b1;
      if (reg_rvalid === 1'b1) begin
        seen = 1'b1;
        got_d = reg_rdata;
      end else @(posedge ref_clk);
    end
    `CHK(seen, 1'b1)
    `CHK(got_d, exp_d)
    `CHK(got_rj, exp_rj)
  endtask

  // table code 010, port in low nibble, then byte offset
  task automatic sel(input logic [3:0] p, input logic [7:0] o);
    wr(`ACL_OFS_CTRL0, {`ACL_TABLE_CODE, 1'b0, p}, 1'b0);
    wr(`ACL_OFS_CTRL1, o, 1'b0);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // watchdog: whole sequence needs well under 20000 cycles
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(`ACL_OFS_CTRL0, 8'h00, 1'b0);
    rd_chk(`ACL_OFS_CTRL1, 8'h00, 1'b0);
    rd_chk(`ACL_OFS_DATA, 8'h00, 1'b1);
    `CHK(field_kind, ACL_FLD_NONE)
    // unmapped place: write lost, answer zero, no reject
    wr(8'h10, 8'h5A, 1'b0);
    rd_chk(8'h10, 8'h00, 1'b0);
    // reserved bit 4 never sticks
    wr(`ACL_OFS_CTRL0, 8'h51, 1'b0);
    rd_chk(`ACL_OFS_CTRL0, 8'h41, 1'b0);
    for (int t = 0; t < 8; t++) begin
      if (t != 2) begin
        wr(`ACL_OFS_CTRL0, {3'(t), 5'h01}, 1'b0);
        rd_chk(`ACL_OFS_DATA, 8'h00, 1'b1);
      end
    end
    // ports outside 1..5 refuse both directions
    foreach (bad_p[k]) begin
      sel(bad_p[k], `ACL_OFS_ADDR_HI);
      wr(`ACL_OFS_DATA, 8'hFF, 1'b1);
      rd_chk(`ACL_OFS_DATA, 8'h00, 1'b1);
    end
    // fill every port first so a port mix-up shows on readback
    for (int p = 1; p <= 5; p++) begin
      for (int o = 6; o <= 9; o++) begin
        sel(4'(p), 8'(o));
        rd_chk(`ACL_OFS_DATA, 8'h00, 1'b0);
        wr(`ACL_OFS_DATA, {4'(p), 4'(o)}, 1'b0);
      end
    end
    for (int p = 1; p <= 5; p++) begin
      for (int o = 6; o <= 9; o++) begin
        sel(4'(p), 8'(o));
        rd_chk(`ACL_OFS_CTRL1, 8'(o), 1'b0);
        rd_chk(`ACL_OFS_DATA, {4'(p), 4'(o)}, 1'b0);
        `CHK(field_kind, acl_field_t'(3'(o - 5)))
      end
    end
    // last valid offset, then the first one past the entry
    sel(4'h5, 8'h0F);
    wr(`ACL_OFS_DATA, 8'hC3, 1'b0);
    rd_chk(`ACL_OFS_DATA, 8'hC3, 1'b0);
    `CHK(field_kind, ACL_FLD_OTHER)
    sel(4'h5, 8'h10);
    wr(`ACL_OFS_DATA, 8'h77, 1'b1);
    rd_chk(`ACL_OFS_DATA, 8'h00, 1'b1);
    sel(4'h5, 8'h0F);
    rd_chk(`ACL_OFS_DATA, 8'hC3, 1'b0);
    // the refused offset 16 must not wrap onto offset 0
    sel(4'h5, 8'h00);
    rd_chk(`ACL_OFS_DATA, 8'h00, 1'b0);
    // write then read on the next edge; answer shows the new byte
    sel(4'h2, `ACL_OFS_TYPE_LO);
    @(posedge ref_clk);
    reg_addr <= `ACL_OFS_DATA;
    reg_wdata <= 8'h3C;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, 8'h3C)
    // clock enable low: write lost, pending answer waits for it
    sel(4'h1, `ACL_OFS_ADDR_HI);
    @(posedge ref_clk);
    reg_addr <= `ACL_OFS_DATA;
    reg_wdata <= 8'hEE;
    reg_wr <= 1'b1;
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    ce <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    ce <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ce <= 1'b1;
    #1;
    `CHK(reg_rvalid, 1'b0)
    @(posedge ref_clk);
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, 8'h16)
    // second reset mid-run clears store, selection and field status
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    `CHK(field_kind, ACL_FLD_NONE)
    rd_chk(`ACL_OFS_CTRL1, 8'h00, 1'b0);
    sel(4'h5, 8'h0F);
    rd_chk(`ACL_OFS_DATA, 8'h00, 1'b0);
    give_verdict();
  end

endmodule // acl_indirect_access_test
`default_nettype wire
